// File: src/pteu_map.svh
// Register offsets, field positions and reset values of the pin task unit
`ifndef PTEU_MAP_SVH
`define PTEU_MAP_SVH

`define PTEU_OFS_DRIVE 12'h000
`define PTEU_OFS_RAISE 12'h030
`define PTEU_OFS_CLEAR 12'h060
`define PTEU_OFS_EDGE 12'h100
`define PTEU_OFS_MULTI 12'h17C
`define PTEU_OFS_IRQ_SET 12'h304
`define PTEU_OFS_IRQ_CLR 12'h308
`define PTEU_OFS_SETUP 12'h510
`define PTEU_BANK_BYTES 12'h020

`define PTEU_POS_MODE 0
`define PTEU_POS_PIN 8
`define PTEU_POS_ACT 16
`define PTEU_POS_INIT 20
`define PTEU_POS_IRQ_MULTI 31

`define PTEU_RST_SETUP 32'h0000_0000
`define PTEU_RST_IRQ_EN 32'h0000_0000
`define PTEU_RST_WORD 32'h0000_0000

`endif

// File: src/pteu_pkg.sv
// Types shared by the pin task unit
package pteu_pkg;

  typedef enum logic [1:0] {
    PTEU_MODE_OFF = 2'b00,
    PTEU_MODE_EVENT = 2'b01,
    PTEU_MODE_RSVD = 2'b10,
    PTEU_MODE_TASK = 2'b11
  } pteu_mode_t;

  // Drive action in task mode, edge selection in event mode
  typedef enum logic [1:0] {
    PTEU_ACT_NONE = 2'b00,
    PTEU_ACT_SET = 2'b01,
    PTEU_ACT_CLEAR = 2'b10,
    PTEU_ACT_TOGGLE = 2'b11
  } pteu_act_t;

  typedef struct packed {
    logic initial_level;
    pteu_act_t action_choice;
    logic [4:0] pin_select;
    pteu_mode_t mode;
  } pteu_setup_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pteu_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pteu_wb_rsp_t;

endpackage

// File: src/pteu.sv
// Eight-channel pin task and event unit with Wishbone register access
`timescale 1ns/100ps
`include "pteu_map.svh"

// Contract
// RULE1: Eight channels, each bound to one pin by its pin_select field.
// RULE2: Each channel has raise, clear and configurable drive tasks.
// RULE3: Edge event on rising edge, falling edge or any change.
// RULE4: Raise task drives the pin high, clear task drives it low.
// RULE5: Drive task sets, clears or inverts per action_choice.
// RULE6: One channel_setup register governs a channel's tasks and event.
// RULE7: A controlling channel alone sets the pin; port value is ignored.
// RULE8: Released pin at once takes port output value and configuration.
// RULE9: Same-cycle tasks: drive first, then clear, then raise.
// RULE10: Drive with action none wins and leaves the pin unchanged.
// RULE11: Entering task mode loads the pin from initial_level.
// RULE12: Multi-pin flag only on rising edge of sense_summary.
// RULE13: A clear leaving flags set gives a fresh sense_summary edge.
// RULE14: Software clears sense sources before idle sleep.
// RULE15: System-off entry with sense_summary high gives wake reset.
// RULE16: Sense_summary edge detection is always active, no clock request.
// RULE17: Software masks irq, sets level_watch, clears flag, unmasks.
// RULE18: Event mode forces input, task mode output, disabled follows port.
// RULE19: Software binds each pin to at most one channel.
// RULE20: Flags stay set until written zero; enabled flags raise irq.
// RULE21: Tasks are one-cycle pulses; pin inputs synchronised first.
module pteu
  import pteu_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int NUM_PINS = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input pteu_wb_req_t wb_req_i,
  output pteu_wb_rsp_t wb_rsp_o,
  // Event crossbar
  input wire logic [NUM_CH-1:0] xbar_drive_i,
  input wire logic [NUM_CH-1:0] xbar_raise_i,
  input wire logic [NUM_CH-1:0] xbar_clear_i,
  output logic [NUM_CH-1:0] evt_edge_o,
  output logic evt_multi_o,
  output logic irq_o,
  // Port logic and pins
  input wire logic [NUM_PINS-1:0] pin_in_i,
  input wire logic [NUM_PINS-1:0] port_out_i,
  input wire logic [NUM_PINS-1:0] port_dir_i,
  input wire logic sense_summary_i,
  output logic [NUM_PINS-1:0] pad_out_o,
  output logic [NUM_PINS-1:0] pad_oe_o,
  // Power control
  input wire logic sys_off_entry_i,
  output logic wake_reset_o
);

  localparam logic [11:0] BANK = `PTEU_BANK_BYTES;

  pteu_setup_t setup [NUM_CH];
  pteu_setup_t next_setup [NUM_CH];
  logic [31:0] irq_en;
  logic [31:0] next_irq_en;
  logic multi_flag;
  logic next_multi_flag;
  logic summary_q;
  logic next_summary_q;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic evt_multi;
  logic next_evt_multi;
  logic wake;
  logic next_wake;
  logic [NUM_PINS-1:0] sync_a;
  logic [NUM_PINS-1:0] sync_b;
  logic [NUM_CH-1:0] lvl;
  logic [NUM_CH-1:0] flag;
  logic [NUM_CH-1:0] prev;
  logic [NUM_CH-1:0] evt_edge;
  logic [NUM_CH-1:0] reg_drive;
  logic [NUM_CH-1:0] reg_raise;
  logic [NUM_CH-1:0] reg_clear;
  logic [NUM_CH-1:0] flag_clr;
  logic [NUM_CH-1:0] setup_wr;
  logic wr;
  logic rd;
  logic [31:0] irq_src;

  function automatic logic in_bank(input logic [11:0] a,
                                   input logic [11:0] base);
    in_bank = (a >= base) && (a < base + BANK);
  endfunction

  function automatic logic [2:0] bank_idx(input logic [11:0] a,
                                          input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    bank_idx = d[4:2];
  endfunction

  // Write takes effect at the edge where ack is seen high
  assign wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && ack;
  assign rd = wb_req_i.cyc && wb_req_i.stb && !ack;

  // Bus decode, register storage and multi-pin event
  always_comb begin
    logic [11:0] a;
    logic [2:0] ix;
    logic [31:0] d;
    a = {wb_req_i.adr[11:2], 2'b00};
    ix = 3'b000;
    d = wb_req_i.dat;
    next_setup = setup;
    next_irq_en = irq_en;
    next_multi_flag = multi_flag;
    next_rdata = `PTEU_RST_WORD;
    reg_drive = '0;
    reg_raise = '0;
    reg_clear = '0;
    flag_clr = '0;
    setup_wr = '0;
    if (in_bank(a, `PTEU_OFS_DRIVE)) begin
      ix = bank_idx(a, `PTEU_OFS_DRIVE);
      reg_drive[ix] = wr && wb_req_i.sel[0] && d[0]; // RULE21
    end else if (in_bank(a, `PTEU_OFS_RAISE)) begin
      ix = bank_idx(a, `PTEU_OFS_RAISE);
      reg_raise[ix] = wr && wb_req_i.sel[0] && d[0]; // RULE21
    end else if (in_bank(a, `PTEU_OFS_CLEAR)) begin
      ix = bank_idx(a, `PTEU_OFS_CLEAR);
      reg_clear[ix] = wr && wb_req_i.sel[0] && d[0]; // RULE21
    end else if (in_bank(a, `PTEU_OFS_EDGE)) begin
      ix = bank_idx(a, `PTEU_OFS_EDGE);
      flag_clr[ix] = wr && wb_req_i.sel[0] && !d[0]; // RULE20
      next_rdata = {31'h0000_0000, flag[ix]};
    end else if (in_bank(a, `PTEU_OFS_SETUP)) begin
      ix = bank_idx(a, `PTEU_OFS_SETUP);
      // Read back in register layout, not in struct order
      next_rdata[`PTEU_POS_MODE +: 2] = setup[ix].mode;
      next_rdata[`PTEU_POS_PIN +: 5] = setup[ix].pin_select;
      next_rdata[`PTEU_POS_ACT +: 2] = setup[ix].action_choice;
      next_rdata[`PTEU_POS_INIT] = setup[ix].initial_level;
      if (wr) begin
        setup_wr[ix] = 1'b1;
        next_setup[ix].mode = pteu_mode_t'(d[`PTEU_POS_MODE +: 2]);
        next_setup[ix].pin_select = d[`PTEU_POS_PIN +: 5]; // RULE1
        next_setup[ix].action_choice =
          pteu_act_t'(d[`PTEU_POS_ACT +: 2]);
        next_setup[ix].initial_level = d[`PTEU_POS_INIT];
      end
    end else if (a == `PTEU_OFS_MULTI) begin
      next_rdata = {31'h0000_0000, multi_flag};
      if (wr && wb_req_i.sel[0] && !d[0]) begin
        next_multi_flag = 1'b0; // RULE20 RULE17
      end
    end else if (a == `PTEU_OFS_IRQ_SET) begin
      next_rdata = irq_en;
      if (wr) begin
        next_irq_en = irq_en | d;
      end
    end else if (a == `PTEU_OFS_IRQ_CLR) begin
      next_rdata = irq_en;
      if (wr) begin
        next_irq_en = irq_en & ~d;
      end
    end
    // Set wins over a clear in the same cycle
    if (next_evt_multi) begin
      next_multi_flag = 1'b1; // RULE20
    end
    // Only mapped bits are kept
    next_irq_en[30:NUM_CH] = '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        setup[i] <= pteu_setup_t'(10'(`PTEU_RST_SETUP));
      end
      irq_en <= `PTEU_RST_IRQ_EN;
      multi_flag <= 1'b0;
      rdata <= `PTEU_RST_WORD;
    end else begin
      setup <= next_setup; // RULE6
      irq_en <= next_irq_en;
      multi_flag <= next_multi_flag;
      rdata <= next_rdata;
    end
  end

  // Bus answer: one wait state, ack stands for one cycle
  always_comb begin
    next_ack = rd;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end

  // Summary edge is watched every cycle, no enable gates it
  always_comb begin
    next_summary_q = sense_summary_i; // RULE16
    next_evt_multi = sense_summary_i && !summary_q; // RULE12 RULE13
    next_wake = sys_off_entry_i && sense_summary_i; // RULE15
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      summary_q <= 1'b0;
      evt_multi <= 1'b0;
      wake <= 1'b0;
    end else begin
      summary_q <= next_summary_q;
      evt_multi <= next_evt_multi;
      wake <= next_wake;
    end
  end

  // Two-stage synchroniser on the pin inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pin_in_i; // RULE21
      sync_b <= sync_a;
    end
  end

  // Per-channel task and event logic
  genvar c;
  for (c = 0; c < NUM_CH; c++) begin : g_ch
    logic next_lvl;
    logic next_flag;
    logic next_prev;
    logic next_evt;
    logic now;
    logic drv;
    logic rse;
    logic clr;
    pteu_setup_t s;

    assign s = next_setup[c];
    assign now = sync_b[setup[c].pin_select];
    assign drv = xbar_drive_i[c] || reg_drive[c];
    assign rse = xbar_raise_i[c] || reg_raise[c];
    assign clr = xbar_clear_i[c] || reg_clear[c];

    always_comb begin
      next_lvl = lvl[c];
      next_flag = flag[c];
      next_prev = now;
      next_evt = 1'b0;
      if (setup_wr[c] && s.mode == PTEU_MODE_TASK &&
          setup[c].mode != PTEU_MODE_TASK) begin
        next_lvl = s.initial_level; // RULE11
      end else if (setup[c].mode == PTEU_MODE_TASK) begin
        if (drv) begin // RULE9 RULE10
          case (setup[c].action_choice) // RULE2 RULE5
            PTEU_ACT_SET: next_lvl = 1'b1;
            PTEU_ACT_CLEAR: next_lvl = 1'b0;
            PTEU_ACT_TOGGLE: next_lvl = !lvl[c];
            default: next_lvl = lvl[c];
          endcase
        end else if (clr) begin
          next_lvl = 1'b0; // RULE4 RULE9
        end else if (rse) begin
          next_lvl = 1'b1; // RULE4
        end
      end
      // A change of pin_select may give one stray edge
      if (setup[c].mode == PTEU_MODE_EVENT) begin
        case (setup[c].action_choice) // RULE3
          PTEU_ACT_SET: next_evt = now && !prev[c];
          PTEU_ACT_CLEAR: next_evt = !now && prev[c];
          PTEU_ACT_TOGGLE: next_evt = now != prev[c];
          default: next_evt = 1'b0;
        endcase
      end
      if (flag_clr[c]) begin
        next_flag = 1'b0;
      end
      if (next_evt) begin
        next_flag = 1'b1; // RULE20
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        lvl[c] <= 1'b0;
        flag[c] <= 1'b0;
        prev[c] <= 1'b0;
        evt_edge[c] <= 1'b0;
      end else begin
        lvl[c] <= next_lvl;
        flag[c] <= next_flag;
        prev[c] <= next_prev;
        evt_edge[c] <= next_evt;
      end
    end
  end

  // Pin ownership; port values apply the moment no channel claims a pin
  genvar p;
  for (p = 0; p < NUM_PINS; p++) begin : g_pin
    always_comb begin
      pad_out_o[p] = port_out_i[p]; // RULE8 RULE18
      pad_oe_o[p] = port_dir_i[p];
      // Last claiming channel wins; overlaps are software's fault
      for (int k = 0; k < NUM_CH; k++) begin
        if (setup[k].pin_select == 5'(p)) begin // RULE19
          if (setup[k].mode == PTEU_MODE_TASK) begin
            pad_out_o[p] = lvl[k]; // RULE7
            pad_oe_o[p] = 1'b1; // RULE18
          end else if (setup[k].mode == PTEU_MODE_EVENT) begin
            pad_out_o[p] = 1'b0; // RULE7
            pad_oe_o[p] = 1'b0; // RULE18
          end
        end
      end
    end
  end

  // Source layout follows the enable mask, whatever the channel count
  always_comb begin
    irq_src = '0;
    irq_src[NUM_CH-1:0] = flag;
    irq_src[`PTEU_POS_IRQ_MULTI] = multi_flag;
  end

  assign irq_o = |(irq_src & irq_en); // RULE20
  assign evt_edge_o = evt_edge;
  assign evt_multi_o = evt_multi;
  assign wake_reset_o = wake;
  assign wb_rsp_o.ack = ack;
  assign wb_rsp_o.dat = rdata;

endmodule

// File: bench/pteu_asserts.sv
// Port-level checks of the pin task unit, bound into it
`timescale 1ns/100ps
module pteu_asserts
  import pteu_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int NUM_PINS = 32
) (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input pteu_wb_req_t wb_req_i,
  input pteu_wb_rsp_t wb_rsp_o,
  // Crossbar and events
  input wire logic [NUM_CH-1:0] xbar_drive_i,
  input wire logic [NUM_CH-1:0] xbar_raise_i,
  input wire logic [NUM_CH-1:0] xbar_clear_i,
  input wire logic [NUM_CH-1:0] evt_edge_o,
  input wire logic evt_multi_o,
  input wire logic irq_o,
  // Pins and power
  input wire logic [NUM_PINS-1:0] port_out_i,
  input wire logic [NUM_PINS-1:0] port_dir_i,
  input wire logic sense_summary_i,
  input wire logic [NUM_PINS-1:0] pad_out_o,
  input wire logic [NUM_PINS-1:0] pad_oe_o,
  input wire logic sys_off_entry_i,
  input wire logic wake_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_multi_rise:
    assert property ($rose(sense_summary_i) |=> evt_multi_o)
    else $error("multi event missing");
  a_multi_cause:
    assert property (evt_multi_o |-> $past(sense_summary_i))
    else $error("multi event without sense");
  a_wake_cause:
    assert property (sys_off_entry_i && sense_summary_i |=> wake_reset_o)
    else $error("no wake reset");
  a_port_after_reset:
    assert property ($past(rst_i) |-> pad_out_o == port_out_i
      && pad_oe_o == port_dir_i) else $error("pads not on port");
  // Pads move only after a task, a register write or a port change
  a_pins_hold:
    assert property (!$past(rst_i) && !$past(wb_rsp_o.ack)
      && !$past(|{xbar_drive_i, xbar_raise_i, xbar_clear_i})
      && $stable(port_out_i) && $stable(port_dir_i)
      |-> $stable(pad_out_o) && $stable(pad_oe_o))
    else $error("pad moved without cause");
  a_irq_hold:
    assert property (irq_o && !wb_rsp_o.ack |=> irq_o)
    else $error("irq dropped without write");
  a_clean_reset:
    assert property ($past(rst_i) |-> !irq_o && !wake_reset_o
      && !(|evt_edge_o)) else $error("outputs set after reset");
  a_ack_answer:
    assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack
      |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack) else $error("bad bus answer");
endmodule

bind pteu pteu_asserts #(.NUM_CH(NUM_CH), .NUM_PINS(NUM_PINS)) chk_u (
  .clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .xbar_drive_i, .xbar_raise_i,
  .xbar_clear_i, .evt_edge_o, .evt_multi_o, .irq_o, .port_out_i,
  .port_dir_i, .sense_summary_i, .pad_out_o, .pad_oe_o, .sys_off_entry_i,
  .wake_reset_o);

// File: bench/pteu_pins.sv
// Pin and port model on the far side of the pads
`timescale 1ns/100ps
module pteu_pins (
  // Pads and outside world
  input wire logic [31:0] pad_out_i,
  input wire logic [31:0] pad_oe_i,
  input wire logic [31:0] ext_i,
  input wire logic [31:0] watch_i,
  // Pin levels and sense
  output logic [31:0] pin_o,
  output logic sense_o
);
  // A driven pad beats the outside source
  assign pin_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
  assign sense_o = |(pin_o & watch_i);
endmodule

// File: bench/tb_pin_task_event_unit.sv
// Self-checking bench of the pin task unit
`timescale 1ns/100ps
`include "pteu_map.svh"
module tb_pin_task_event_unit import pteu_pkg::*; ();
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic look = 1'h0;
  logic look_l = 1'h0;
  logic [31:0] ql[$];
  logic [31:0] qe[$];
  logic sys_off = 1'h0;
  logic sense, wake, multi, irq;
  pteu_wb_req_t wb_req_i = '0;
  pteu_wb_rsp_t wb_rsp_o;
  logic [7:0] xd = 8'h0, xr = 8'h0, xc = 8'h0, edg;
  logic [31:0] pin, pad, oe, port = 32'h0, dir = 32'h0;
  logic [31:0] ext = 32'h0, watch = 32'h0;
  logic [31:0] qr[$];
  logic [31:0] qp[$];
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int qi = 0;
  integer seed = 32'he7e2;
  pteu dut_u (.clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .xbar_drive_i(xd),
    .xbar_raise_i(xr), .xbar_clear_i(xc), .evt_edge_o(edg),
    .evt_multi_o(multi), .irq_o(irq), .pin_in_i(pin), .port_out_i(port),
    .port_dir_i(dir), .sense_summary_i(sense), .pad_out_o(pad),
    .pad_oe_o(oe), .sys_off_entry_i(sys_off), .wake_reset_o(wake));
  pteu_pins pins_u (.pad_out_i(pad), .pad_oe_i(oe), .ext_i(ext),
    .watch_i(watch), .pin_o(pin), .sense_o(sense));
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [31:0] su(input logic [1:0] m,
      input logic [4:0] p, input logic [1:0] a, input logic i);
    return {11'h0, i, 2'h0, a, 3'h0, p, 6'h0, m};
  endfunction
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Holds the request until ack is seen at an edge
  task automatic wb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    wb_req_i <= '{1'h1, 1'h1, w, a, 4'hf, d};
    do @(negedge clk_i); while (wb_rsp_o.ack !== 1'h1);
    @(posedge clk_i);
    wb_req_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    qr.push_back(e);
    wb(1'h0, a, 32'h0);
  endtask
  task automatic chk(input int p, input logic [1:0] e);
    qi = p;
    qp.push_back({30'h0, e});
    look <= 1'h1;
    @(posedge clk_i);
    look <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic pwr(input logic [1:0] e);
    ql.push_back({30'h0, e});
    look_l <= 1'h1;
    @(posedge clk_i);
    look_l <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic xb(input logic [7:0] d, input logic [7:0] c,
      input logic [7:0] r);
    xd <= d;
    xc <= c;
    xr <= r;
    @(posedge clk_i);
    {xd, xc, xr} <= 24'h0;
    @(posedge clk_i);
  endtask
  // Outputs are looked at mid-cycle, where they have settled
  always @(negedge clk_i) begin
    if (wb_rsp_o.ack === 1'h1 && wb_req_i.we === 1'h0 && qr.size() > 0)
      cmp(qr.pop_front(), wb_rsp_o.dat);
    if (look === 1'h1) cmp(qp.pop_front(), {30'h0, oe[qi], pad[qi]});
    if (look_l === 1'h1) cmp(ql.pop_front(), {30'h0, wake, irq});
    if (edg !== 8'h0 || multi !== 1'h0)
      cmp(qe.pop_front(), {23'h0, multi, edg});
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    rdc(`PTEU_OFS_SETUP + 12'h01c, 32'h0);
    wb(1'h1, 12'h7f0, 32'hffff_ffff);
    rdc(12'h7f0, 32'h0);
    wb(1'h1, `PTEU_OFS_SETUP, su(2'h3, 5'h05, 2'h3, 1'h1));
    chk(5, 2'h3);
    port <= 32'hffff_ffff;
    wb(1'h1, `PTEU_OFS_DRIVE, 32'h1);
    chk(5, 2'h2);
    xb(8'h0, 8'h0, 8'h1);
    chk(5, 2'h3);
    wb(1'h1, `PTEU_OFS_CLEAR, 32'h1);
    chk(5, 2'h2);
    xb(8'h1, 8'h1, 8'h1);
    chk(5, 2'h3);
    xb(8'h0, 8'h1, 8'h1);
    chk(5, 2'h2);
    // Mode stays task, so initial_level must not be reloaded here
    for (int a = 1; a < 3; a++) begin
      wb(1'h1, `PTEU_OFS_SETUP, su(2'h3, 5'h05, a[1:0], 1'h0));
      wb(1'h1, `PTEU_OFS_DRIVE, 32'h1);
      chk(5, {1'h1, a == 1});
    end
    wb(1'h1, `PTEU_OFS_SETUP, su(2'h3, 5'h05, 2'h0, 1'h0));
    xb(8'h1, 8'h0, 8'h1);
    chk(5, 2'h2);
    port <= $random(seed);
    dir <= $random(seed);
    wb(1'h1, `PTEU_OFS_SETUP, 32'h0);
    chk(5, {dir[5], port[5]});
    dir <= 32'h0;
    wb(1'h1, `PTEU_OFS_IRQ_SET, 32'h8000_0080);
    rdc(`PTEU_OFS_IRQ_CLR, 32'h8000_0080);
    for (int s = 1; s < 4; s++) begin
      wb(1'h1, `PTEU_OFS_SETUP + 12'h01c, su(2'h1, 5'h09, s[1:0], 1'h0));
      repeat (6) @(posedge clk_i);
      wb(1'h1, `PTEU_OFS_EDGE + 12'h01c, 32'h0);
      if (s != 2) qe.push_back(32'h80);
      ext[9] <= 1'h1;
      repeat (6) @(posedge clk_i);
      rdc(`PTEU_OFS_EDGE + 12'h01c, {31'h0, s != 2});
      wb(1'h1, `PTEU_OFS_EDGE + 12'h01c, 32'h0);
      if (s != 1) qe.push_back(32'h80);
      ext[9] <= 1'h0;
      repeat (6) @(posedge clk_i);
      rdc(`PTEU_OFS_EDGE + 12'h01c, {31'h0, s != 1});
    end
    pwr(2'h1);
    wb(1'h1, `PTEU_OFS_IRQ_CLR, 32'h8000_0080);
    watch <= 32'h0010_0000;
    wb(1'h1, `PTEU_OFS_MULTI, 32'h0);
    wb(1'h1, `PTEU_OFS_IRQ_SET, 32'h8000_0000);
    qe.push_back(32'h100);
    ext[20] <= 1'h1;
    repeat (3) @(posedge clk_i);
    rdc(`PTEU_OFS_MULTI, 32'h1);
    wb(1'h1, `PTEU_OFS_MULTI, 32'h0);
    sys_off <= 1'h1;
    @(posedge clk_i);
    pwr(2'h2);
    rdc(`PTEU_OFS_MULTI, 32'h0);
    sys_off <= 1'h0;
    ext[20] <= 1'h0;
    repeat (3) @(posedge clk_i);
    qe.push_back(32'h100);
    ext[20] <= 1'h1;
    repeat (3) @(posedge clk_i);
    rdc(`PTEU_OFS_MULTI, 32'h1);
    wrap_up();
  end
endmodule
